/* pkg/erc_pkg.sv */
package erc_pkg;

   localparam int unsigned ERC_NUM_EVENTS = 18;

   localparam logic [11:0] ERC_PENDING_OFFSET      = 12'h c00;
   localparam logic [11:0] ERC_STATUS_CLEAR_OFFSET = 12'h c20;
   localparam logic [11:0] ERC_STATUS_SET_OFFSET   = 12'h c40;
   localparam logic [11:0] ERC_ENABLE_OFFSET       = 12'h c60;
   localparam logic [11:0] ERC_ENABLE_CLEAR_OFFSET = 12'h c80;
   localparam logic [11:0] ERC_ENABLE_SET_OFFSET   = 12'h ca0;
   localparam logic [11:0] ERC_POLARITY_OFFSET     = 12'h cc0;
   localparam logic [11:0] ERC_TYPE_OFFSET         = 12'h ce0;
   localparam logic [11:0] ERC_RAW_STATUS_OFFSET   = 12'h d20;
   localparam logic [11:0] ERC_INT_MASK_OFFSET     = 12'h d40;
   localparam logic [11:0] ERC_INT_STATUS_OFFSET   = 12'h d60;

   localparam logic [17:0] ERC_ENABLE_RESET   = 18'h3ffff;
   localparam logic [17:0] ERC_POLARITY_RESET = 18'h3c00f;
   localparam logic [17:0] ERC_TYPE_RESET     = 18'h3ffff;
   localparam logic [17:0] ERC_RAW_RESET      = 18'h00000;

   localparam int unsigned ERC_IRQ_BITS = 2;
   localparam int unsigned ERC_IRQ_FORWARD_BIT = 0;
   localparam int unsigned ERC_IRQ_ERROR_BIT   = 1;

   typedef struct packed {
      logic        sel;
      logic        enable;
      logic        write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } erc_apb_req_t;

   typedef struct packed {
      logic [31:0] rdata;
      logic        ready;
      logic        slverr;
   } erc_apb_rsp_t;

endpackage

/* rtl/erc_event_router.sv */
`timescale 1ns/1ps
// Operation
// - Enable-clear write clears each enable bit written as one, others kept.
// - Enable-set write sets each enable bit written as one; both ports write-only.
// - Bits 31 to 18 of every register read as zero; software writes zero.
// - Polarity one means high level or rising edge; zero means low or falling; reset 3c00f.
// - Type one latches the event on an edge; reset 3ffff.
// - Type zero passes the event through as a level.
// - A latched event stays asserted until the status-clear port clears it.
// - Latched events use edge detection so a held input does not reassert.
// - Raw status shows all events before enabling, reset zero.
// - A pending bit sets on its event while enabled, or on a status-set write.
// - Status-clear write of one clears the pending bit; zero leaves it.
// - Enabled events are forwarded, disabled ones held back; enable resets to all ones.
// - Status-set write of one sets the matching pending bit.
module erc_event_router
   import erc_pkg::*;
#(
   parameter int unsigned N = ERC_NUM_EVENTS
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic [N-1:0] event_in,
   output logic      [N-1:0] event_forward,
   output logic              vic_request,
   output logic              irq
);

   erc_apb_req_t req;
   erc_apb_rsp_t rsp;

   logic [N-1:0] enable_reg;
   logic [N-1:0] polarity_reg;
   logic [N-1:0] type_reg;
   logic [N-1:0] latch_reg;
   logic [N-1:0] active_prev_reg;
   logic [N-1:0] pending_reg;
   logic [ERC_IRQ_BITS-1:0] int_mask_reg;
   logic [ERC_IRQ_BITS-1:0] int_status_reg;
   logic [N-1:0] active;
   logic [N-1:0] rise;
   logic [N-1:0] raw_status;
   logic [N-1:0] wbits;
   logic         wr_access;
   logic         rd_access;
   logic         mapped;
   logic [31:0]  rdata_next;
   logic [N-1:0] pending_clr;
   logic [N-1:0] pending_set;
   logic [N-1:0] sw_set;
   logic [ERC_IRQ_BITS-1:0] irq_event;
   logic [ERC_IRQ_BITS-1:0] irq_read_clear;

   function automatic logic is_write_hit(input erc_apb_req_t r, input logic [11:0] off);
      return r.sel && r.enable && r.write && (r.addr == off);
   endfunction

   assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
   assign wbits = req.wdata[N-1:0];
   assign wr_access = req.sel && req.enable && req.write;
   assign rd_access = req.sel && req.enable && !req.write;

   // Polarity folds each input into an active-high view.
   assign active = ~(event_in ^ polarity_reg);
   // A latch only fires on the transition into the active level.
   assign rise = active & ~active_prev_reg;
   // Latched bits for edge events, live level for direct events.
   assign raw_status = (type_reg & latch_reg) | (~type_reg & active);

   // The edge history resets to inactive, so a pin that is already active when reset
   // is released counts as one edge and latches once.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_prev_reg <= '0;
      end else begin
         active_prev_reg <= active;
      end
   end

   // Set beats clear so an edge in the clearing cycle is kept.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_reg <= ERC_RAW_RESET;
      end else begin
         if (is_write_hit(req, ERC_STATUS_CLEAR_OFFSET)) begin
            latch_reg <= (latch_reg & ~wbits) | rise;
         end else begin
            latch_reg <= latch_reg | rise;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_reg <= ERC_ENABLE_RESET;
      end else if (is_write_hit(req, ERC_ENABLE_CLEAR_OFFSET)) begin
         enable_reg <= enable_reg & ~wbits;
      end else if (is_write_hit(req, ERC_ENABLE_SET_OFFSET)) begin
         enable_reg <= enable_reg | wbits;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         polarity_reg <= ERC_POLARITY_RESET;
         type_reg     <= ERC_TYPE_RESET;
      end else begin
         if (is_write_hit(req, ERC_POLARITY_OFFSET)) begin
            polarity_reg <= wbits;
         end
         if (is_write_hit(req, ERC_TYPE_OFFSET)) begin
            type_reg <= wbits;
         end
      end
   end

   // A raw bit being cleared by this write is kept out of the set term, otherwise the old
   // latch would re-arm pending; a fresh edge still reaches pending one cycle later.
   assign pending_clr = is_write_hit(req, ERC_STATUS_CLEAR_OFFSET) ? wbits : '0;
   assign sw_set      = is_write_hit(req, ERC_STATUS_SET_OFFSET) ? wbits : '0;
   assign pending_set = (raw_status & ~pending_clr & enable_reg) | sw_set;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending_reg <= '0;
      end else begin
         pending_reg <= (pending_reg & ~pending_clr) | pending_set;
      end
   end

   // Forwarding is a flop so the controller sees a clean level.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_forward <= '0;
         vic_request   <= 1'b0;
      end else begin
         event_forward <= pending_reg & enable_reg;
         vic_request   <= |(pending_reg & enable_reg);
      end
   end

   // Write-only ports and unmapped words both read as zero, so no stale data leaks out.
   always_comb begin
      mapped     = 1'b1;
      rdata_next = '0;
      unique case (req.addr)
         ERC_PENDING_OFFSET:      rdata_next[N-1:0] = pending_reg;
         ERC_ENABLE_OFFSET:       rdata_next[N-1:0] = enable_reg;
         ERC_POLARITY_OFFSET:     rdata_next[N-1:0] = polarity_reg;
         ERC_TYPE_OFFSET:         rdata_next[N-1:0] = type_reg;
         ERC_RAW_STATUS_OFFSET:   rdata_next[N-1:0] = raw_status;
         ERC_INT_MASK_OFFSET:     rdata_next[ERC_IRQ_BITS-1:0] = int_mask_reg;
         ERC_INT_STATUS_OFFSET:   rdata_next[ERC_IRQ_BITS-1:0] = int_status_reg;
         ERC_STATUS_CLEAR_OFFSET,
         ERC_STATUS_SET_OFFSET,
         ERC_ENABLE_CLEAR_OFFSET,
         ERC_ENABLE_SET_OFFSET:   rdata_next = '0;
         default:                 mapped = 1'b0;
      endcase
   end

   // Zero-wait slave; the error answer flags unmapped addresses only.
   assign rsp     = '{rdata: rdata_next, ready: 1'b1, slverr: req.sel && req.enable && !mapped};
   assign pready  = rsp.ready;
   assign pslverr = rsp.slverr;
   assign prdata  = rd_access ? rsp.rdata : '0;

   // Block interrupt: bit 0 notes a new forward request, bit 1 a bus error.
   always_comb begin
      irq_event                      = '0;
      irq_event[ERC_IRQ_FORWARD_BIT] = (|(pending_reg & enable_reg)) && !vic_request;
      irq_event[ERC_IRQ_ERROR_BIT]   = rsp.slverr;
   end
   // Reading the status clears it, but an event in the same cycle is kept.
   assign irq_read_clear = (rd_access && req.addr == ERC_INT_STATUS_OFFSET) ? '1 : '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_mask_reg   <= '0;
         int_status_reg <= '0;
      end else begin
         int_status_reg <= (int_status_reg & ~irq_read_clear) | irq_event;
         if (is_write_hit(req, ERC_INT_MASK_OFFSET)) begin
            int_mask_reg <= req.wdata[ERC_IRQ_BITS-1:0];
         end
      end
   end

   assign irq = |(int_status_reg & int_mask_reg);

   AST_ENABLE_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      is_write_hit(req, ERC_ENABLE_CLEAR_OFFSET) |=> ((enable_reg & $past(wbits)) == '0)
      && ((enable_reg & ~$past(wbits)) == ($past(enable_reg) & ~$past(wbits))))
      else $error("enable clear misbehaved");

   AST_ENABLE_SET: assert property (@(posedge pclk) disable iff (!presetn)
      is_write_hit(req, ERC_ENABLE_SET_OFFSET) |=> ((enable_reg & $past(wbits)) == $past(wbits)))
      else $error("enable set misbehaved");

   AST_RESERVED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      rd_access |-> (prdata[31:N] == '0))
      else $error("reserved bits not zero");

   AST_LATCH_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      (latch_reg != '0 && !is_write_hit(req, ERC_STATUS_CLEAR_OFFSET))
      |=> ((latch_reg & $past(latch_reg)) == $past(latch_reg)))
      else $error("latched event lost without clear");

   AST_NO_RELATCH: assert property (@(posedge pclk) disable iff (!presetn)
      ($stable(active) && is_write_hit(req, ERC_STATUS_CLEAR_OFFSET) && $past(presetn))
      |=> ((latch_reg & $past(wbits)) == '0))
      else $error("held input relatched after clear");

   AST_LEVEL_PASS: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_access && req.addr == ERC_RAW_STATUS_OFFSET)
      |-> ((prdata[N-1:0] & ~type_reg) == (~(event_in ^ polarity_reg) & ~type_reg)))
      else $error("level event not passed through");

   AST_STATUS_SET: assert property (@(posedge pclk) disable iff (!presetn)
      is_write_hit(req, ERC_STATUS_SET_OFFSET) |=> ((pending_reg & $past(wbits)) == $past(wbits)))
      else $error("status set failed");

   AST_REQUEST: assert property (@(posedge pclk) disable iff (!presetn)
      (|(pending_reg & enable_reg)) |=> vic_request)
      else $error("request not raised");

   AST_POLARITY_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      is_write_hit(req, ERC_POLARITY_OFFSET) |=> (polarity_reg == $past(wbits)))
      else $error("polarity write not stored");

   AST_TYPE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      is_write_hit(req, ERC_TYPE_OFFSET) |=> (type_reg == $past(wbits)))
      else $error("type write not stored");

   AST_EDGE_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
      (rise != '0) |=> ((latch_reg & $past(rise)) == $past(rise)))
      else $error("edge did not set its latch");

   AST_LATCH_ONLY_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> ((latch_reg & ~$past(latch_reg) & ~$past(rise)) == '0))
      else $error("latch set without an edge");

   AST_LATCH_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      (is_write_hit(req, ERC_STATUS_CLEAR_OFFSET) && ((rise & wbits) == '0))
      |=> ((latch_reg & $past(wbits)) == '0))
      else $error("latch not cleared by status clear");

   AST_RAW_LATCHED: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_access && req.addr == ERC_RAW_STATUS_OFFSET)
      |-> ((prdata[N-1:0] & type_reg) == (latch_reg & type_reg)))
      else $error("raw status hides a latched event");

   AST_PENDING_ENABLED: assert property (@(posedge pclk) disable iff (!presetn)
      !is_write_hit(req, ERC_STATUS_CLEAR_OFFSET) |=> ((pending_reg & $past(raw_status)
      & $past(enable_reg)) == ($past(raw_status) & $past(enable_reg))))
      else $error("enabled event not made pending");

   AST_PENDING_MASKED: assert property (@(posedge pclk) disable iff (!presetn)
      !is_write_hit(req, ERC_STATUS_SET_OFFSET) |=> ((pending_reg & ~$past(pending_reg)
      & ~($past(raw_status) & $past(enable_reg))) == '0))
      else $error("disabled event made pending");

   AST_PENDING_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      is_write_hit(req, ERC_STATUS_CLEAR_OFFSET) |=> ((pending_reg & $past(wbits)) == '0))
      else $error("pending bit not cleared");

   AST_PENDING_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      !is_write_hit(req, ERC_STATUS_CLEAR_OFFSET)
      |=> ((pending_reg & $past(pending_reg)) == $past(pending_reg)))
      else $error("pending bit lost without clear");

   AST_ENABLE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      !(is_write_hit(req, ERC_ENABLE_CLEAR_OFFSET) || is_write_hit(req, ERC_ENABLE_SET_OFFSET))
      |=> (enable_reg == $past(enable_reg)))
      else $error("enable changed without a port write");

   AST_FORWARD: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> (event_forward == ($past(pending_reg) & $past(enable_reg))))
      else $error("forwarded events do not match enabled pending");

   AST_REQUEST_LOW: assert property (@(posedge pclk) disable iff (!presetn)
      ((pending_reg & enable_reg) == '0) |=> !vic_request)
      else $error("request raised with nothing pending");

   AST_WO_READ: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_access && (req.addr == ERC_ENABLE_CLEAR_OFFSET || req.addr == ERC_ENABLE_SET_OFFSET))
      |-> (prdata == '0))
      else $error("write-only port read not zero");

   AST_ERROR_READ_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_access && !mapped) |-> (prdata == '0))
      else $error("unmapped read not zero");

endmodule

/* testbench/erc_event_src.sv */
`timescale 1ns/1ps
module erc_event_src (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [17:0] act,
   input  wire logic [17:0] pol,
   output logic      [17:0] event_in
);
   // Held at the inactive level in reset so no stray edge is latched on release.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_in <= ~pol;
      end else begin
         event_in <= ~(act ^ pol);
      end
   end
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
   import erc_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, vic_request, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, ob, oc;
   logic [17:0] event_in, event_forward, act, pol, en_m, m;
   int          mismatches, n_checks, k, b, c;

   erc_event_router u_erc_event_router (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .event_in(event_in), .event_forward(event_forward),
      .vic_request(vic_request), .irq(irq));
   erc_event_src u_erc_event_src (.pclk(pclk), .presetn(presetn), .act(act), .pol(pol),
      .event_in(event_in));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_pin(input string nm, input logic [17:0] e, input logic [17:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 16) begin
         mismatches++;
         report_and_stop();
      end
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk_reg($sformatf("reg %h", a), e, rd);
   endtask

   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
      pwdata = 32'h0; act = 18'h0; pol = 18'h3c00f; mismatches = 0; n_checks = 0;
      k = $urandom(32'hfb6cb1a2);
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rchk(ERC_POLARITY_OFFSET, 32'h3c00f);
      rchk(ERC_TYPE_OFFSET, 32'h3ffff);
      rchk(ERC_ENABLE_OFFSET, 32'h3ffff);
      apb(1'b1, ERC_RAW_STATUS_OFFSET, 32'h3ffff);
      rchk(ERC_RAW_STATUS_OFFSET, 32'h0);
      $display("test reset values done");
      en_m = 18'h3ffff;
      for (k = 0; k < 4; k++) begin
         m = 18'($urandom);
         apb(1'b1, ERC_ENABLE_CLEAR_OFFSET, {14'h0, m});
         en_m &= ~m;
         rchk(ERC_ENABLE_OFFSET, {14'h0, en_m});
         m = 18'($urandom);
         apb(1'b1, ERC_ENABLE_SET_OFFSET, {14'h0, m});
         en_m |= m;
         rchk(ERC_ENABLE_OFFSET, {14'h0, en_m});
      end
      rchk(ERC_ENABLE_SET_OFFSET, 32'h0);
      rchk(ERC_ENABLE_CLEAR_OFFSET, 32'h0);
      apb(1'b1, ERC_ENABLE_SET_OFFSET, 32'h3ffff);
      $display("test enable ports done");
      // A high-active bit takes the edge test, a low-active bit the level test.
      b = $urandom % 4;
      c = 4 + $urandom % 10;
      ob = 32'h1 << b;
      oc = 32'h1 << c;
      act[b] <= 1'b1;
      repeat (3) @(posedge pclk);
      act[b] <= 1'b0;
      repeat (6) @(posedge pclk);
      rchk(ERC_RAW_STATUS_OFFSET, ob);
      rchk(ERC_PENDING_OFFSET, ob);
      chk_pin("vic_request", 18'h1, {17'h0, vic_request});
      chk_pin("event_forward", ob[17:0], event_forward);
      chk_pin("irq", 18'h0, {17'h0, irq});
      act[b] <= 1'b1;
      repeat (6) @(posedge pclk);
      apb(1'b1, ERC_STATUS_CLEAR_OFFSET, ob);
      repeat (6) @(posedge pclk);
      rchk(ERC_RAW_STATUS_OFFSET, 32'h0);
      rchk(ERC_PENDING_OFFSET, 32'h0);
      act[b] <= 1'b0;
      $display("test latched event done");
      apb(1'b1, ERC_TYPE_OFFSET, 32'h3ffff & ~oc);
      act[c] <= 1'b1;
      repeat (4) @(posedge pclk);
      rchk(ERC_RAW_STATUS_OFFSET, oc);
      act[c] <= 1'b0;
      repeat (4) @(posedge pclk);
      rchk(ERC_RAW_STATUS_OFFSET, 32'h0);
      apb(1'b1, ERC_STATUS_CLEAR_OFFSET, oc);
      rchk(ERC_PENDING_OFFSET, 32'h0);
      $display("test level event done");
      rchk(ERC_INT_STATUS_OFFSET, 32'h1);
      apb(1'b1, ERC_INT_MASK_OFFSET, 32'h1);
      apb(1'b1, ERC_STATUS_SET_OFFSET, oc);
      repeat (4) @(posedge pclk);
      rchk(ERC_PENDING_OFFSET, oc);
      chk_pin("irq", 18'h1, {17'h0, irq});
      apb(1'b1, ERC_ENABLE_CLEAR_OFFSET, oc);
      repeat (4) @(posedge pclk);
      chk_pin("event_forward", 18'h0, event_forward);
      chk_pin("vic_request", 18'h0, {17'h0, vic_request});
      rchk(ERC_INT_STATUS_OFFSET, 32'h1);
      rchk(ERC_INT_STATUS_OFFSET, 32'h0);
      chk_pin("irq", 18'h0, {17'h0, irq});
      apb(1'b0, 12'hd00, 32'h0);
      chk_pin("pslverr", 18'h1, {17'h0, err});
      chk_reg("unmapped read", 32'h0, rd);
      rchk(ERC_INT_STATUS_OFFSET, 32'h2);
      $display("test software events and interrupt done");
      m = 18'($urandom);
      apb(1'b1, ERC_POLARITY_OFFSET, {14'h0, m});
      rchk(ERC_POLARITY_OFFSET, {14'h0, m});
      apb(1'b1, ERC_TYPE_OFFSET, {14'h0, ~m});
      rchk(ERC_TYPE_OFFSET, {14'h0, ~m});
      $display("test configuration write done");
      report_and_stop();
   end
endmodule
